// ==== sspl_pkg.sv ====
// Shared constants, types and helpers for the synchronous serial port link
package sspl_pkg;

    // ========================================================================
    // Sizes and field layout
    localparam int unsigned DATA_W = 16;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned FSS_W = 4;
    localparam int unsigned CNT_W = 5;
    localparam logic [3:0] FSS_MIN = 4'h3;
    localparam logic [3:0] FSS_RESET = 4'h3;

    // ========================================================================
    // Timing: serial clock half period in core clock cycles
    localparam int unsigned SCK_HALF_CYCLES = 4;
    localparam int unsigned SYNC_STAGES = 2;

    // ========================================================================
    // Bus formats
    typedef enum logic [1:0] {
        FMT_SPI = 2'h0,
        FMT_SSI = 2'h1,
        FMT_THREE_WIRE = 2'h2
    } fmt_e;

    // Master sequencer, one-hot
    typedef enum logic [3:0] {
        M_IDLE = 4'h1,
        M_LEAD = 4'h2,
        M_SHIFT = 4'h4,
        M_TAIL = 4'h8
    } mst_state_e;

    // Frame length in bits; unsupported codes are forced to the shortest
    function automatic logic [CNT_W-1:0] frame_bits(input logic [3:0] fss);
        logic [3:0] f;
        f = (fss < FSS_MIN) ? FSS_MIN : fss;
        frame_bits = {1'b0, f} + 5'h01;
    endfunction : frame_bits

    // Active level of the frame select line for a format
    function automatic logic sel_level(input logic [1:0] fmt);
        sel_level = (fmt == FMT_SSI);
    endfunction : sel_level

    // Idle level of the serial clock; only the SPI format may invert it
    function automatic logic idle_clk(input logic [1:0] fmt, input logic cpol);
        idle_clk = (fmt == FMT_SPI) ? cpol : 1'b0;
    endfunction : idle_clk

endpackage : sspl_pkg

// ==== sspl_fifo.sv ====
// Frame FIFO with its own storage and a registered read port
`timescale 1ns/1ps
module sspl_fifo
    import sspl_pkg::*;
#(
    parameter int unsigned W = DATA_W,
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Fill side
    input wire logic push_in,
    input wire logic [W-1:0] push_data_in,
    output logic ready_out,
    // Drain side
    input wire logic pop_in,
    output logic [W-1:0] pop_data_out,
    output logic valid_out
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic ready_nxt, valid_nxt, do_push, do_pop;

    // ========================================================================
    // Pointers and flags
    always_comb begin
        do_push = push_in && ready_out;
        do_pop = pop_in && valid_out;
        wp_nxt = do_push ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt = do_pop ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r;
        if (do_push && !do_pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (do_pop && !do_push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
        ready_nxt = (cnt_nxt != (AW+1)'(DEPTH));
        // A word written this edge to the slot being read shows one later
        valid_nxt = (cnt_nxt != '0) && !(do_push && (wp_r == rp_nxt));
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            ready_out <= 1'b1;
            valid_out <= 1'b0;
            pop_data_out <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            ready_out <= ready_nxt;
            valid_out <= valid_nxt;
            pop_data_out <= mem_r[rp_nxt];
            if (do_push) begin
                mem_r[wp_r] <= push_data_in;
            end
        end
    end

endmodule : sspl_fifo

// ==== sync_serial_port_link.sv ====
// Synchronous serial port controller: master or slave, three bus formats
`timescale 1ns/1ps
module sync_serial_port_link
    import sspl_pkg::*;
#(
    parameter int unsigned HALF_CYCLES = SCK_HALF_CYCLES,
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    // Core clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Configuration, held steady while frames run
    input wire logic port_reset_release_bits_in,
    input wire logic master_mode_in,
    input wire logic [1:0] fmt_sel_in,
    input wire logic cpol_in,
    input wire logic [FSS_W-1:0] frame_size_select_in,
    // Transmit words from the CPU side
    input wire logic tx_valid_in,
    input wire logic [DATA_W-1:0] tx_data_in,
    output logic tx_ready_out,
    // Received words to the CPU side
    output logic rx_valid_out,
    output logic [DATA_W-1:0] rx_data_out,
    input wire logic rx_ready_in,
    // Status
    output logic busy_out,
    output logic rx_overrun_out,
    // Serial clock pin; the input clocks the slave logic
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n_out,
    // Frame select pin
    input wire logic sel_in,
    output logic sel_out,
    output logic sel_oe_n_out,
    // Master in, slave out pin
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_n_out,
    // Master out, slave in pin
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_n_out
);
    localparam int unsigned HW = $clog2(HALF_CYCLES + 1);
    localparam logic [HW-1:0] HALF_LAST = HW'(HALF_CYCLES - 1);

    // ========================================================================
    // Common decode
    logic rst;
    logic [CNT_W-1:0] len;
    logic sel_act_lvl, clk_idle, is_master;
    assign rst = srst_in || !port_reset_release_bits_in;
    assign len = frame_bits(frame_size_select_in);
    assign sel_act_lvl = sel_level(fmt_sel_in);
    assign clk_idle = idle_clk(fmt_sel_in, cpol_in);
    assign is_master = master_mode_in;

    // ========================================================================
    // FIFOs
    logic txf_pop, txf_valid;
    logic [DATA_W-1:0] txf_data;
    logic rxf_push, rxf_ready;
    logic [DATA_W-1:0] rxf_data;

    sspl_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
        .clk_in(core_clk_in),
        .srst_in(rst),
        .push_in(tx_valid_in),
        .push_data_in(tx_data_in),
        .ready_out(tx_ready_out),
        .pop_in(txf_pop),
        .pop_data_out(txf_data),
        .valid_out(txf_valid)
    );

    sspl_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
        .clk_in(core_clk_in),
        .srst_in(rst),
        .push_in(rxf_push),
        .push_data_in(rxf_data),
        .ready_out(rxf_ready),
        .pop_in(rx_ready_in),
        .pop_data_out(rx_data_out),
        .valid_out(rx_valid_out)
    );

    // ========================================================================
    // Pin and slave completion toggle synchronisers
    logic [1:0] miso_s_r, sel_s_r, done_s_r;
    logic done_prev_r;
    logic lk_done_t_r;

    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            miso_s_r <= 2'h0;
            // Start at the idle select level so no false busy follows reset
            sel_s_r <= {2{!sel_act_lvl}};
            done_s_r <= 2'h0;
            done_prev_r <= 1'b0;
        end else begin
            miso_s_r <= {miso_s_r[0], miso_in};
            sel_s_r <= {sel_s_r[0], sel_in};
            done_s_r <= {done_s_r[0], lk_done_t_r};
            done_prev_r <= done_s_r[1];
        end
    end

    // ========================================================================
    // Slave logic on the serial clock
    logic lk_clk, lk_sel, lk_clr;
    logic [CNT_W-1:0] lk_cnt_r, lk_cnt_nxt;
    logic [DATA_W-1:0] lk_sh_r, lk_sh_nxt, lk_word_r;
    logic lk_miso_r, lk_miso_nxt, lk_mvld_r;
    logic [DATA_W-1:0] slv_word_r;

    // Clock polarity is static config, so the XOR only picks an edge
    assign lk_clk = sck_in ^ clk_idle;
    assign lk_sel = (sel_in == sel_act_lvl) && !is_master;
    // A dropped select ends the frame without waiting for a clock edge
    assign lk_clr = rst || !lk_sel;

    always_comb begin
        lk_sh_nxt = {lk_sh_r[DATA_W-2:0], mosi_in};
        lk_cnt_nxt = (lk_cnt_r == len - 5'h01) ? '0 : lk_cnt_r + 5'h01;
        // Word bit for the next falling edge, MSB first
        lk_miso_nxt = slv_word_r[4'(len - 5'h01 - lk_cnt_r)];
    end

    always_ff @(posedge lk_clk or posedge lk_clr) begin
        if (lk_clr) begin
            lk_cnt_r <= '0;
            lk_sh_r <= '0;
        end else begin
            lk_cnt_r <= lk_cnt_nxt;
            lk_sh_r <= lk_sh_nxt;
        end
    end

    // Completion toggle and word survive the select dropping
    always_ff @(posedge lk_clk or posedge rst) begin
        if (rst) begin
            lk_done_t_r <= 1'b0;
            lk_word_r <= '0;
        end else if (lk_sel && lk_cnt_r == len - 5'h01) begin
            lk_done_t_r <= !lk_done_t_r;
            lk_word_r <= lk_sh_nxt;
        end
    end

    always_ff @(negedge lk_clk or posedge lk_clr) begin
        if (lk_clr) begin
            lk_miso_r <= 1'b0;
            lk_mvld_r <= 1'b0;
        end else begin
            lk_miso_r <= lk_miso_nxt;
            lk_mvld_r <= 1'b1;
        end
    end

    // Before the first falling edge the MSB is shown straight from the word
    assign miso_out = lk_mvld_r ? lk_miso_r : slv_word_r[4'(len - 5'h01)];
    assign miso_oe_n_out = !lk_sel;

    // ========================================================================
    // Core side of the slave: feed the next word, collect the received one
    logic slv_done, slv_loaded_r, slv_loaded_nxt, slv_pop;
    logic [DATA_W-1:0] slv_word_nxt;

    always_comb begin
        slv_done = (done_s_r[1] != done_prev_r) && !is_master;
        slv_pop = !is_master && !slv_loaded_r && txf_valid;
        slv_loaded_nxt = slv_loaded_r;
        slv_word_nxt = slv_word_r;
        if (slv_done) begin
            slv_loaded_nxt = 1'b0;
            slv_word_nxt = '0;
        end else if (slv_pop) begin
            slv_loaded_nxt = 1'b1;
            slv_word_nxt = txf_data;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            slv_loaded_r <= 1'b0;
            slv_word_r <= '0;
        end else begin
            slv_loaded_r <= slv_loaded_nxt;
            slv_word_r <= slv_word_nxt;
        end
    end

    // ========================================================================
    // Master sequencer
    mst_state_e st_r, st_nxt;
    logic [HW-1:0] half_r, half_nxt;
    logic [CNT_W-1:0] bit_r, bit_nxt;
    logic [DATA_W-1:0] mtx_r, mtx_nxt, mrx_r, mrx_nxt;
    logic sck_nxt, sel_nxt, mosi_nxt, m_done, m_pop, half_end;

    always_comb begin
        st_nxt = st_r;
        half_nxt = half_r;
        bit_nxt = bit_r;
        mtx_nxt = mtx_r;
        mrx_nxt = mrx_r;
        sck_nxt = clk_idle;
        sel_nxt = !sel_act_lvl;
        mosi_nxt = mosi_out;
        m_done = 1'b0;
        m_pop = 1'b0;
        half_end = (half_r == HALF_LAST);
        case (st_r)
            M_IDLE: begin
                half_nxt = '0;
                bit_nxt = '0;
                if (is_master && txf_valid) begin
                    m_pop = 1'b1;
                    // Left-justify so bit DATA_W-1 is always the next bit
                    mtx_nxt = txf_data << (5'h10 - len);
                    mosi_nxt = mtx_nxt[DATA_W-1];
                    sel_nxt = sel_act_lvl;
                    st_nxt = M_LEAD;
                end
            end
            M_LEAD: begin
                sel_nxt = sel_act_lvl;
                half_nxt = half_end ? '0 : half_r + 1'b1;
                if (half_end) begin
                    sck_nxt = !clk_idle;
                    st_nxt = M_SHIFT;
                end
            end
            M_SHIFT: begin
                sel_nxt = sel_act_lvl;
                sck_nxt = sck_out;
                half_nxt = half_end ? '0 : half_r + 1'b1;
                if (half_end) begin
                    sck_nxt = !sck_out;
                    if (sck_out != clk_idle) begin
                        // Trailing edge: sample, then present the next bit
                        mrx_nxt = {mrx_r[DATA_W-2:0], miso_s_r[1]};
                        mtx_nxt = {mtx_r[DATA_W-2:0], 1'b0};
                        mosi_nxt = mtx_nxt[DATA_W-1];
                        bit_nxt = bit_r + 5'h01;
                        if (bit_r == len - 5'h01) begin
                            st_nxt = M_TAIL;
                        end
                    end
                end
            end
            M_TAIL: begin
                sel_nxt = sel_act_lvl;
                half_nxt = half_end ? '0 : half_r + 1'b1;
                if (half_end) begin
                    sel_nxt = !sel_act_lvl;
                    m_done = 1'b1;
                    st_nxt = M_IDLE;
                end
            end
            default: begin
                st_nxt = M_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            st_r <= M_IDLE;
            half_r <= '0;
            bit_r <= '0;
            mtx_r <= '0;
            mrx_r <= '0;
            sck_out <= 1'b0;
            sel_out <= 1'b1;
            mosi_out <= 1'b0;
        end else begin
            st_r <= st_nxt;
            half_r <= half_nxt;
            bit_r <= bit_nxt;
            mtx_r <= mtx_nxt;
            mrx_r <= mrx_nxt;
            sck_out <= sck_nxt;
            sel_out <= sel_nxt;
            mosi_out <= mosi_nxt;
        end
    end

    // ========================================================================
    // Shared pops, received words, pin enables and status
    logic [DATA_W-1:0] len_mask;
    assign len_mask = DATA_W'(17'h1FFFF >> (5'h11 - len));
    assign txf_pop = m_pop || slv_pop;
    assign rxf_push = m_done || slv_done;
    assign rxf_data = (m_done ? mrx_nxt : lk_word_r) & len_mask;

    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            sck_oe_n_out <= 1'b1;
            sel_oe_n_out <= 1'b1;
            mosi_oe_n_out <= 1'b1;
            busy_out <= 1'b0;
            rx_overrun_out <= 1'b0;
        end else begin
            // Only the master drives clock, select and MOSI
            sck_oe_n_out <= !is_master;
            sel_oe_n_out <= !is_master;
            mosi_oe_n_out <= !is_master;
            busy_out <= (st_nxt != M_IDLE)
                || (!is_master && sel_s_r[1] == sel_act_lvl);
            // Full receive FIFO drops the word and flags it for one cycle
            rx_overrun_out <= rxf_push && !rxf_ready;
        end
    end

endmodule : sync_serial_port_link

// ==== sspl_asserts.sv ====
// Pin-level assertion checker for the serial port link
`timescale 1ns/1ps
module sspl_asserts
    import sspl_pkg::*;
#(
    parameter int unsigned HALF_CYCLES = SCK_HALF_CYCLES
) (
    // Core side
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic port_reset_release_bits_in,
    input wire logic master_mode_in,
    input wire logic [1:0] fmt_sel_in,
    input wire logic cpol_in,
    input wire logic tx_valid_in,
    input wire logic tx_ready_out,
    input wire logic rx_valid_out,
    input wire logic busy_out,
    // Serial pins
    input wire logic sck_out,
    input wire logic sck_oe_n_out,
    input wire logic sel_in,
    input wire logic sel_out,
    input wire logic sel_oe_n_out,
    input wire logic miso_oe_n_out,
    input wire logic mosi_out,
    input wire logic mosi_oe_n_out
);
    // ====================
    // Levels and settling
    logic rst;
    logic act;
    logic idl;
    logic mst;
    logic [1:0] up_r;
    logic [1:0] up_nxt;
    assign rst = srst_in || !port_reset_release_bits_in;
    assign act = (fmt_sel_in == FMT_SSI);
    assign idl = (fmt_sel_in == FMT_SPI) ? cpol_in : 1'b0;
    // Outputs take a few edges after reset to follow the configuration
    assign mst = master_mode_in && (up_r == 2'h3);
    always_comb begin
        up_nxt = rst ? 2'h0 : ((up_r == 2'h3) ? up_r : up_r + 2'h1);
    end
    always_ff @(posedge core_clk_in) begin
        up_r <= up_nxt;
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst);
    sequence lead_s;
        sck_out != idl && $past(sck_out) == idl;
    endsequence
    sequence sel_on_s;
        sel_out == act && $past(sel_out) != act;
    endsequence
    sequence sel_off_s;
        sel_out != act && $past(sel_out) == act;
    endsequence
    // ====================
    // Properties
    sck_idle_a: assert property (mst && !busy_out |-> sck_out == idl)
        else $error("serial clock left idle level outside a frame");
    sel_idle_a: assert property (mst && !busy_out |-> sel_out != act)
        else $error("select active outside a frame");
    sel_lead_a: assert property ((mst and sel_on_s) |->
        sck_out == idl ##HALF_CYCLES sck_out != idl)
        else $error("select did not lead the clock");
    sck_half_a: assert property ((mst and lead_s) |->
        ##HALF_CYCLES (sck_out == idl && $past(sck_out) != idl))
        else $error("serial clock half period wrong");
    mosi_edge_a: assert property (mst && sel_out == act &&
        $past(sel_out) == act && $changed(mosi_out) |->
        sck_out == idl && $past(sck_out) != idl)
        else $error("output data changed off the trailing edge");
    sel_tail_a: assert property ((mst and sel_off_s) |->
        $past(sck_out) == idl ##[1:3] rx_valid_out)
        else $error("frame end without idle clock or received word");
    pin_oe_a: assert property (up_r == 2'h3 |->
        {sck_oe_n_out, sel_oe_n_out, mosi_oe_n_out} == {3{!master_mode_in}})
        else $error("pin drive does not follow the mode");
    miso_oe_a: assert property (
        miso_oe_n_out == (master_mode_in || sel_in != act))
        else $error("return data pin drive wrong");
    tx_full_a: assert property ($fell(tx_ready_out) |-> $past(tx_valid_in))
        else $error("transmit ready fell without a push");
endmodule : sspl_asserts

bind sync_serial_port_link sspl_asserts #(.HALF_CYCLES(HALF_CYCLES)) u_chk (
    .core_clk_in(core_clk_in), .srst_in(srst_in),
    .port_reset_release_bits_in(port_reset_release_bits_in),
    .master_mode_in(master_mode_in), .fmt_sel_in(fmt_sel_in),
    .cpol_in(cpol_in), .tx_valid_in(tx_valid_in),
    .tx_ready_out(tx_ready_out), .rx_valid_out(rx_valid_out),
    .busy_out(busy_out), .sck_out(sck_out), .sck_oe_n_out(sck_oe_n_out),
    .sel_in(sel_in), .sel_out(sel_out), .sel_oe_n_out(sel_oe_n_out),
    .miso_oe_n_out(miso_oe_n_out), .mosi_out(mosi_out),
    .mosi_oe_n_out(mosi_oe_n_out)
);

// ==== sspl_far_end.sv ====
// Far-side bus partner: slave to a master port, master to a slave port
`timescale 1ns/1ps
module sspl_far_end (
    // Resolved bus pins
    input wire logic sck_in,
    input wire logic sel_in,
    input wire logic mosi_in,
    input wire logic miso_in,
    // Role and frame setup
    input wire logic slv_en_in,
    input wire logic act_lvl_in,
    input wire logic idle_in,
    input wire logic [4:0] len_in,
    input wire logic [15:0] tx_word_in,
    // Driven pins and captured word
    output logic sck_out,
    output logic sel_out,
    output logic mosi_out,
    output logic miso_out,
    output logic [15:0] rx_word_out
);
    int cnt;
    logic on;
    assign on = slv_en_in && (sel_in === act_lvl_in);
    initial begin
        sck_out = 1'b0;
        sel_out = 1'b1;
        mosi_out = 1'b0;
        miso_out = 1'b0;
        rx_word_out = 16'h0000;
    end
    // ====================
    // Slave role
    always @(on) begin
        cnt = 0;
        if (on) begin
            rx_word_out = 16'h0000;
            miso_out = tx_word_in[int'(len_in) - 1];
        end else begin
            // A released line must not keep showing the last bit
            miso_out = ~miso_out;
        end
    end
    always @(sck_in) begin
        if (on && sck_in !== idle_in) begin
            rx_word_out = {rx_word_out[14:0], mosi_in};
            cnt++;
        end else if (on && cnt < int'(len_in)) begin
            miso_out = tx_word_in[int'(len_in) - 1 - cnt];
        end
    end
    // ====================
    // Master role, 30 ns clock only inside the frame
    task automatic park();
        sel_out = ~act_lvl_in;
        sck_out = idle_in;
    endtask : park
    task automatic xfer(input int n);
        #7;
        rx_word_out = 16'h0000;
        sel_out = act_lvl_in;
        for (int i = int'(len_in) - 1; i >= int'(len_in) - n; i--) begin
            mosi_out = tx_word_in[i];
            #15;
            sck_out = ~idle_in;
            rx_word_out = {rx_word_out[14:0], miso_in};
            #15;
            sck_out = idle_in;
        end
        #15;
        sel_out = ~act_lvl_in;
        mosi_out = ~mosi_out;
    endtask : xfer
endmodule : sspl_far_end

// ==== sync_serial_port_link_tb.sv ====
// Self-checking bench for the serial port link
`timescale 1ns/1ps
module sync_serial_port_link_tb
    import sspl_pkg::*;
;
    logic clk, srst, rel, mm, cpol, txv, rxr, act, idle;
    logic [1:0] fmt;
    logic [3:0] fss;
    logic [4:0] len;
    logic [15:0] txd, rxd, f_tx, f_rx;
    logic txr, rxv, busy, ovr, sck_o, sck_oe, sel_o, sel_oe;
    logic miso_o, miso_oe, mosi_o, mosi_oe, f_sck, f_sel, f_mosi, f_miso;
    wire logic sck_w, sel_w, miso_w, mosi_w;
    int err_count, num_checks, ovr_seen;
    // Each pin follows whichever side enables it
    assign sck_w = (sck_oe === 1'b0) ? sck_o : f_sck;
    assign sel_w = (sel_oe === 1'b0) ? sel_o : f_sel;
    assign mosi_w = (mosi_oe === 1'b0) ? mosi_o : f_mosi;
    assign miso_w = (miso_oe === 1'b0) ? miso_o : f_miso;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    sync_serial_port_link #(.HALF_CYCLES(4), .DEPTH(8)) DUT (
        .core_clk_in(clk), .srst_in(srst), .port_reset_release_bits_in(rel),
        .master_mode_in(mm), .fmt_sel_in(fmt), .cpol_in(cpol),
        .frame_size_select_in(fss), .tx_valid_in(txv), .tx_data_in(txd),
        .tx_ready_out(txr), .rx_valid_out(rxv), .rx_data_out(rxd),
        .rx_ready_in(rxr), .busy_out(busy), .rx_overrun_out(ovr),
        .sck_in(sck_w), .sck_out(sck_o), .sck_oe_n_out(sck_oe),
        .sel_in(sel_w), .sel_out(sel_o), .sel_oe_n_out(sel_oe),
        .miso_in(miso_w), .miso_out(miso_o), .miso_oe_n_out(miso_oe),
        .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe_n_out(mosi_oe)
    );
    sspl_far_end FAR (
        .sck_in(sck_w), .sel_in(sel_w), .mosi_in(mosi_w), .miso_in(miso_w),
        .slv_en_in(mm), .act_lvl_in(act), .idle_in(idle), .len_in(len),
        .tx_word_in(f_tx), .sck_out(f_sck), .sel_out(f_sel),
        .mosi_out(f_mosi), .miso_out(f_miso), .rx_word_out(f_rx)
    );
    always @(posedge clk) begin
        if (ovr === 1'b1) ovr_seen++;
    end
    // ====================
    // Access tasks
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cfg(input logic m, input logic [1:0] f, input logic c,
                       input logic [3:0] s);
        rel <= 1'b0;
        mm <= m;
        fmt <= f;
        cpol <= c;
        fss <= s;
        act = (f == FMT_SSI);
        idle = (f == FMT_SPI) && c;
        len = {1'b0, s} + 5'h01;
        repeat (2) @(posedge clk);
        FAR.park();
        rel <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : cfg
    task automatic push(input logic [15:0] w);
        txv <= 1'b1;
        txd <= w;
        for (int i = 0; i < 200; i++) begin
            @(posedge clk);
            if (txr === 1'b1) break;
        end
        txv <= 1'b0;
        @(posedge clk);
    endtask : push
    task automatic pop(input logic [15:0] exp);
        for (int i = 0; i < 2000; i++) begin
            @(posedge clk);
            if (rxv === 1'b1) break;
        end
        chk("rx_data", exp, rxd);
        rxr <= 1'b1;
        @(posedge clk);
        rxr <= 1'b0;
    endtask : pop
    task automatic mframe(input logic [1:0] f, input logic c,
                          input logic [3:0] s, input logic [15:0] w, pw);
        cfg(1'b1, f, c, s);
        f_tx = pw;
        push(w);
        repeat (3) @(posedge clk);
        chk("busy", 16'h0001, {15'h0, busy});
        pop(pw);
        chk("far_rx", w & ~(16'hFFFF << len), f_rx);
    endtask : mframe
    task automatic final_report();
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    // ====================
    // Tests
    initial begin
        {srst, rel, mm, cpol, txv, rxr, act, idle} = 8'hC0;
        fmt = 2'h0;
        fss = 4'h7;
        len = 5'h08;
        {txd, f_tx} = 32'h0;
        {err_count, num_checks, ovr_seen} = '0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("tx_ready", 16'h0001, {15'h0, txr});
        chk("busy", 16'h0000, {15'h0, busy});
        mframe(FMT_SPI, 1'b0, 4'h3, 16'hFFFA, 16'h0005);
        mframe(FMT_SPI, 1'b1, 4'hF, 16'hC3A5, 16'h5A3C);
        mframe(FMT_SSI, 1'b0, 4'h7, 16'h0096, 16'h0069);
        mframe(FMT_THREE_WIRE, 1'b0, 4'hB, 16'h0ABC, 16'h0543);
        cfg(1'b0, FMT_SPI, 1'b0, 4'h7);
        f_tx = 16'h00FF;
        FAR.xfer(3);
        repeat (10) @(posedge clk);
        chk("rx_valid", 16'h0000, {15'h0, rxv});
        // The slave's shift word takes one frame beyond the eight queued
        for (int i = 0; i < 9; i++) begin
            push(16'h00A0 + 16'(i));
        end
        chk("tx_ready", 16'h0000, {15'h0, txr});
        txv <= 1'b1;
        txd <= 16'h00EE;
        repeat (3) @(posedge clk);
        txv <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            f_tx = 16'h0050 + 16'(i);
            FAR.xfer(8);
            repeat (10) @(posedge clk);
            chk("far_rx", (i < 9) ? 16'h00A0 + 16'(i) : 16'h0, f_rx);
        end
        chk("overrun", 16'h0002, 16'(ovr_seen));
        for (int i = 0; i < 8; i++) begin
            pop(16'h0050 + 16'(i));
        end
        repeat (4) @(posedge clk);
        chk("rx_valid", 16'h0000, {15'h0, rxv});
        final_report();
    end
    initial begin
        #1000000;
        err_count++;
        final_report();
    end
endmodule : sync_serial_port_link_tb
